//--- hdl/irq_src_defines.vh
// constants for the prioritized interrupt source logic
`ifndef IRQ_SRC_DEFINES_VH
`define IRQ_SRC_DEFINES_VH
`define NUM_LEVELS 16
`define LVL_W 5
`define VEC_TOP 16'hFFFE
`define VEC_SWI 16'hFFFC
`define ADDR_STAT1 8'h00
`define ADDR_STAT2 8'h04
`define ADDR_STAT3 8'h08
`define ADDR_ENABLE 8'h0C
`define ADDR_FLAGS 8'h10
`define ADDR_CTRL 8'h14
`define ADDR_CORE 8'h18
`define ENABLE_RESET 32'h0000_0000
`define CTRL_RESET 8'h00
`define CTRL_WATCH 0
`define CTRL_SP_MODE_FAULT_EN 1
`define CTRL_MASTER 2
`define CTRL_EXT_MASK 3
`define CTRL_KEY_MASK 4
`define CTRL_CONV_EN 5
`define CTRL_TICK_EN 6
`define CTRL_IBIT 7
`define HTRANS_NONSEQ 2'b10
`define ZERO32 32'h0000_0000
`endif

//--- hdl/irq_prio_pick.v
// fixed-priority picker: lowest level number wins
`timescale 1ns/1ns
`include "irq_src_defines.vh"
module irq_prio_pick #(
  parameter N = `NUM_LEVELS
) (
  input wire [N-1:0] req,
  output reg any,
  output reg [`LVL_W-1:0] level
);
  integer i;
  always @* begin
    any = 1'b0;
    level = {`LVL_W{1'b0}};
    // scan from the lowest priority up so the highest overwrites
    for (i = N - 1; i >= 0; i = i - 1) begin
      if (req[i]) begin
        any = 1'b1;
        level = i[`LVL_W-1:0] + 5'h01;
      end
    end
  end
endmodule

//--- hdl/irq_source_ctrl.v
// interrupt source gathering, masking and prioritising with ahb-lite registers
//
// Implementation choices: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ns
`include "irq_src_defines.vh"
module irq_source_ctrl (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire hready,
  input wire [31:0] hwdata,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire ext_request_pin_n,
  input wire [7:0] keypad_pin_n,
  input wire clock_inactive,
  input wire break_hit,
  input wire soft_trap_instr,
  input wire instr_done,
  input wire [15:0] pc_in,
  input wire [3:0] timer_one_ev,
  input wire [3:0] timer_two_ev,
  input wire sp_rx_load,
  input wire sp_tx_load,
  input wire sp_ss_n,
  input wire sp_busy,
  input wire sp_rx_read,
  input wire uart_tx_load,
  input wire uart_tx_idle,
  input wire uart_rx_load,
  input wire uart_rx_read,
  input wire uart_rx_bit,
  input wire uart_long_char,
  input wire [2:0] uart_err_ev,
  input wire conv_done,
  input wire tick_roll,
  input wire rti_done,
  output reg irq_take,
  output reg [15:0] irq_vector,
  output reg [15:0] stack_pc,
  output reg [`LVL_W-1:0] irq_level,
  output reg ibit
);
  // flag bit positions in the flags register
  localparam F_EXT = 0, F_CLK = 1, F_T1C0 = 2, F_T1C1 = 3, F_T1W = 4;
  localparam F_T2C0 = 5, F_T2C1 = 6, F_T2W = 7, F_SPRX = 8, F_SPOV = 9;
  localparam F_SPMF = 10, F_SPTX = 11, F_UOR = 12, F_UNF = 13, F_UFE = 14;
  localparam F_UPE = 15, F_URX = 16, F_UIDL = 17, F_UTX = 18, F_UTC = 19;
  localparam F_KEY = 20, F_CONV = 21, F_TICK = 22, NF = 23;

  // synchronisers for pins; clock-lost resets low so no false loss after reset
  reg [11:0] s1_r, s2_r;
  wire [11:0] pins = {uart_rx_bit, sp_ss_n, clock_inactive, keypad_pin_n,
    ext_request_pin_n};
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_r <= 12'hDFF;
      s2_r <= 12'hDFF;
    end else begin
      s1_r <= pins;
      s2_r <= s1_r;
    end
  end
  wire ext_low = ~s2_r[0];
  wire key_low = ~&s2_r[8:1];
  wire clk_gone = s2_r[9];
  wire ss_n = s2_r[10];
  reg ss_prev_r;

  reg [NF-1:0] flag_r, flag_nxt;
  reg [NF-1:0] en_r;
  reg [7:0] ctrl_r;
  reg [3:0] ones_r;
  reg sp_unread_r, u_unread_r, idle_armed_r;
  wire uart_rx_s = s2_r[11];

  // ahb address phase capture
  reg wr_pend_r, rd_pend_r;
  reg [7:0] addr_r;
  wire take = hsel & hready & htrans[1];
  wire wr_ctrl = wr_pend_r & (addr_r == `ADDR_CTRL);
  wire wr_en = wr_pend_r & (addr_r == `ADDR_ENABLE);
  wire wr_flag = wr_pend_r & (addr_r == `ADDR_FLAGS);

  // event vector for flag setting
  reg [NF-1:0] set_ev;
  always @* begin
    set_ev = {NF{1'b0}};
    set_ev[F_EXT] = ext_low;
    set_ev[F_CLK] = ctrl_r[`CTRL_WATCH] & clk_gone;
    set_ev[F_T1C0] = timer_one_ev[0];
    set_ev[F_T1C1] = timer_one_ev[1];
    set_ev[F_T1W] = timer_one_ev[2];
    set_ev[F_T2C0] = timer_two_ev[0];
    set_ev[F_T2C1] = timer_two_ev[1];
    set_ev[F_T2W] = timer_two_ev[2];
    set_ev[F_SPRX] = sp_rx_load;
    set_ev[F_SPOV] = sp_rx_load & sp_unread_r;
    set_ev[F_SPMF] = ctrl_r[`CTRL_SP_MODE_FAULT_EN] & (ctrl_r[`CTRL_MASTER] ?
      (ss_prev_r & ~ss_n) : (~ss_prev_r & ss_n & sp_busy));
    set_ev[F_SPTX] = sp_tx_load;
    set_ev[F_UOR] = uart_rx_load & u_unread_r;
    set_ev[F_UNF] = uart_err_ev[0];
    set_ev[F_UFE] = uart_err_ev[1];
    set_ev[F_UPE] = uart_err_ev[2];
    set_ev[F_URX] = uart_rx_load;
    set_ev[F_UIDL] = idle_armed_r & (ones_r == (uart_long_char ? 4'hB : 4'hA));
    set_ev[F_UTX] = uart_tx_load;
    set_ev[F_UTC] = uart_tx_idle & ~flag_r[F_UTC] & ~uart_tx_load;
    set_ev[F_KEY] = key_low;
    set_ev[F_CONV] = conv_done & ctrl_r[`CTRL_CONV_EN];
    set_ev[F_TICK] = tick_roll;
  end

  // set wins over a clear in the same cycle
  always @* begin
    flag_nxt = flag_r;
    if (wr_flag) flag_nxt = flag_r & ~hwdata[NF-1:0];
    if (wr_ctrl & hwdata[`CTRL_TICK_EN + 8]) flag_nxt[F_TICK] = 1'b0;
    flag_nxt = flag_nxt | set_ev;
  end

  // gated source requests, grouped into levels
  wire [NF-1:0] g = flag_r & en_r;
  wire [15:0] lvl_req;
  assign lvl_req[0] = flag_r[F_EXT] & ~ctrl_r[`CTRL_EXT_MASK];
  assign lvl_req[1] = g[F_CLK];
  assign lvl_req[2] = g[F_T1C0];
  assign lvl_req[3] = g[F_T1C1];
  assign lvl_req[4] = g[F_T1W];
  assign lvl_req[5] = g[F_T2C0];
  assign lvl_req[6] = g[F_T2C1];
  assign lvl_req[7] = g[F_T2W];
  assign lvl_req[8] = g[F_SPRX] | g[F_SPOV] | g[F_SPMF];
  assign lvl_req[9] = g[F_SPTX];
  assign lvl_req[10] = |g[F_UPE:F_UOR];
  assign lvl_req[11] = g[F_URX] | g[F_UIDL];
  assign lvl_req[12] = g[F_UTX] | g[F_UTC];
  assign lvl_req[13] = flag_r[F_KEY] & ~ctrl_r[`CTRL_KEY_MASK];
  assign lvl_req[14] = flag_r[F_CONV];
  assign lvl_req[15] = flag_r[F_TICK] & ctrl_r[`CTRL_TICK_EN];

  wire any_req;
  wire [`LVL_W-1:0] top_level;
  irq_prio_pick #(.N(`NUM_LEVELS)) u_pick (
    .req(lvl_req),
    .any(any_req),
    .level(top_level)
  );

  wire trap = soft_trap_instr | break_hit;
  wire hw_go = instr_done & any_req & ~ibit;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag_r <= {NF{1'b0}};
      en_r <= {NF{1'b0}};
      ctrl_r <= `CTRL_RESET;
      ibit <= 1'b1;
      irq_take <= 1'b0;
      irq_vector <= `VEC_TOP;
      stack_pc <= 16'h0000;
      irq_level <= {`LVL_W{1'b0}};
      ss_prev_r <= 1'b1;
      ones_r <= 4'h0;
      idle_armed_r <= 1'b0;
      sp_unread_r <= 1'b0;
      u_unread_r <= 1'b0;
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      addr_r <= 8'h00;
      hrdata <= `ZERO32;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
      ss_prev_r <= ss_n;
      if (sp_rx_load) sp_unread_r <= 1'b1;
      else if (sp_rx_read) sp_unread_r <= 1'b0;
      if (uart_rx_load) u_unread_r <= 1'b1;
      else if (uart_rx_read) u_unread_r <= 1'b0;
      // idle count advances once per hclk cycle while the receive line is high
      if (uart_rx_load) idle_armed_r <= 1'b1;
      if (!uart_rx_s) ones_r <= 4'h0;
      else if (ones_r != 4'hF) ones_r <= ones_r + 4'h1;
      if (set_ev[F_UIDL]) idle_armed_r <= 1'b0;
      irq_take <= 1'b0;
      if (trap) begin
        irq_take <= 1'b1;
        irq_vector <= `VEC_SWI;
        stack_pc <= pc_in;
        irq_level <= {`LVL_W{1'b0}};
        ibit <= 1'b1;
      end else if (hw_go) begin
        irq_take <= 1'b1;
        irq_vector <= `VEC_TOP - {10'h000, top_level, 1'b0} - 16'h0002;
        stack_pc <= pc_in - 16'h0001;
        irq_level <= top_level;
        ibit <= 1'b1;
      end else if (rti_done) begin
        ibit <= 1'b0;
      end else if (wr_ctrl) begin
        ibit <= hwdata[`CTRL_IBIT];
      end
      if (wr_ctrl) ctrl_r <= hwdata[7:0];
      if (wr_en) en_r <= hwdata[NF-1:0];
      // bus: zero wait states, always okay
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend_r <= take & hwrite;
      rd_pend_r <= take & ~hwrite;
      if (take) addr_r <= haddr;
      if (take & ~hwrite) begin
        if (haddr == `ADDR_STAT1) hrdata <= {24'h0, lvl_req[5:0], 2'b00};
        else if (haddr == `ADDR_STAT2) hrdata <= {24'h0, lvl_req[13:6]};
        else if (haddr == `ADDR_STAT3) hrdata <= {30'h0, lvl_req[15:14]};
        else if (haddr == `ADDR_ENABLE) hrdata <= {9'h0, en_r};
        else if (haddr == `ADDR_FLAGS) hrdata <= {9'h0, flag_r};
        else if (haddr == `ADDR_CTRL) hrdata <= {24'h0, ibit, ctrl_r[6:0]};
        else if (haddr == `ADDR_CORE) hrdata <= {11'h0, irq_level, stack_pc};
        else hrdata <= `ZERO32;
      end
    end
  end
endmodule

//--- testbench/irq_src_asserts.sv
// checker on interrupt entry, masking and vectors
`timescale 1ns/1ns
module irq_src_asserts (
  input wire hclk,
  input wire hresetn,
  input wire soft_trap_instr,
  input wire break_hit,
  input wire instr_done,
  input wire [15:0] pc_in,
  input wire irq_take,
  input wire [15:0] irq_vector,
  input wire [15:0] stack_pc,
  input wire [4:0] irq_level,
  input wire ibit
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire trap = soft_trap_instr | break_hit;
  sequence s_hw; instr_done && !ibit && !trap ##1 irq_take; endsequence
  property p_trap; soft_trap_instr |=> irq_take && irq_vector == 16'hFFFC &&
    stack_pc == $past(pc_in); endproperty
  property p_brk; break_hit |=> irq_take && irq_level == 5'h0; endproperty
  property p_hwpc; s_hw |-> stack_pc == $past(pc_in) - 16'h1 && irq_level != 5'h0; endproperty
  property p_vec; irq_take && irq_level != 5'h0 |->
    irq_vector == 16'hFFFC - {10'h000, irq_level, 1'h0}; endproperty
  property p_mask; ibit && !trap |=> !irq_take; endproperty
  property p_entry; irq_take |=> ibit; endproperty
  property p_one; irq_take && !trap |=> !irq_take; endproperty
  property p_idle; !instr_done && !trap |=> !irq_take; endproperty
  a_trap: assert property (p_trap) else $error("trap entry wrong");
  a_brk: assert property (p_brk) else $error("break not taken as trap");
  a_hwpc: assert property (p_hwpc) else $error("hardware stack pc wrong");
  a_vec: assert property (p_vec) else $error("vector does not match level");
  a_mask: assert property (p_mask) else $error("entry while masked");
  a_entry: assert property (p_entry) else $error("mask not set on entry");
  a_one: assert property (p_one) else $error("second entry preempts");
  a_idle: assert property (p_idle) else $error("entry off a boundary");
endmodule

//--- testbench/core_model.sv
// core stand-in: instruction boundaries and program counter
`timescale 1ns/1ns
module core_model (
  input wire hclk,
  input wire hresetn,
  input wire [3:0] gap,
  input wire irq_take,
  input wire [15:0] irq_vector,
  output reg instr_done,
  output reg [15:0] pc_in
);
  reg [3:0] cnt_r;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r <= 4'h0;
      instr_done <= 1'h0;
      pc_in <= 16'h8000;
    end else begin
      // boundary every gap+1 cycles, so slow instructions are covered too
      instr_done <= cnt_r == gap;
      cnt_r <= (cnt_r == gap) ? 4'h0 : cnt_r + 4'h1;
      if (irq_take)
        pc_in <= irq_vector;
      else if (cnt_r == gap)
        pc_in <= pc_in + 16'h1;
    end
  end
endmodule

//--- testbench/tb_prioritized_interrupt_source_logic.sv
// bench for the interrupt source controller
`timescale 1ns/1ns
`include "irq_src_defines.vh"
module tb_prioritized_interrupt_source_logic;
  reg hclk, hresetn, hsel, hwrite, trap, brk;
  reg [7:0] haddr;
  reg [1:0] htrans;
  reg [31:0] hwdata, rd;
  reg [16:1] p;
  reg [6:0] mx;
  reg [3:0] gap;
  reg [4:0] tk_lvl;
  reg [15:0] tk_vec;
  wire [31:0] hrdata;
  wire hreadyout, hresp, instr_done, irq_take, ibit;
  wire [15:0] pc_in, irq_vector, stack_pc;
  wire [4:0] irq_level;
  integer fails, num_checks, tk_n, l, a, b, n0;
  irq_source_ctrl dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ext_request_pin_n(!p[1]),
    .keypad_pin_n({7'h7F, !p[14]}), .clock_inactive(p[2]), .break_hit(brk),
    .soft_trap_instr(trap), .instr_done(instr_done), .pc_in(pc_in),
    .timer_one_ev({1'h0, p[5:3]}), .timer_two_ev({1'h0, p[8:6]}), .sp_rx_load(p[9]),
    .sp_tx_load(p[10]), .sp_ss_n(mx[0]), .sp_busy(mx[1]), .sp_rx_read(mx[2]),
    .uart_tx_load(p[13]), .uart_tx_idle(mx[3]), .uart_rx_load(p[12]), .uart_rx_read(mx[4]),
    .uart_rx_bit(mx[5]), .uart_long_char(mx[6]), .uart_err_ev({2'h0, p[11]}),
    .conv_done(p[15]), .tick_roll(p[16]), .rti_done(1'h0), .irq_take(irq_take),
    .irq_vector(irq_vector), .stack_pc(stack_pc), .irq_level(irq_level), .ibit(ibit));
  core_model core (.hclk(hclk), .hresetn(hresetn), .gap(gap), .irq_take(irq_take),
    .irq_vector(irq_vector), .instr_done(instr_done), .pc_in(pc_in));
  task chk(input [31:0] s, input [31:0] e, input string nm);
    num_checks = num_checks + 1;
    if (s !== e) begin
      fails = fails + 1;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task bus(input [7:0] ad, input w, input [31:0] d);
    @(posedge hclk);
    hsel <= 1'h1;
    haddr <= ad;
    htrans <= `HTRANS_NONSEQ;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'h1) @(posedge hclk);
    htrans <= 2'h0;
    hsel <= 1'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'h1) @(posedge hclk);
    rd = hrdata;
  endtask
  function [7:0] sa(input integer v);
    sa = v < 7 ? `ADDR_STAT1 : v < 15 ? `ADDR_STAT2 : `ADDR_STAT3;
  endfunction
  function integer sb(input integer v);
    sb = v < 7 ? v + 1 : v < 15 ? v - 7 : v - 15;
  endfunction
  function [31:0] st(input [16:1] m, input [7:0] ad);
    integer k;
    st = 32'h0;
    for (k = 1; k < 17; k = k + 1)
      if (m[k] && sa(k) == ad) st = st | (32'h1 << sb(k));
  endfunction
  task wait_take;
    integer i;
    for (i = 0; i < 60 && tk_n == n0; i = i + 1) @(posedge hclk);
  endtask
  // raise sources in m while masked, then unmask and expect level e
  task run(input [16:1] m, input integer e);
    n0 = tk_n;
    @(posedge hclk);
    p <= m;
    @(posedge hclk);
    p <= 16'h0;
    repeat (6) @(posedge hclk);
    bus(sa(e), 1'h0, 32'h0);
    chk(rd, st(m, sa(e)), "status");
    chk(tk_n, n0, "masked");
    bus(`ADDR_CTRL, 1'h1, 32'h63);
    wait_take;
    chk(tk_n, n0 + 1, "taken");
    chk(tk_lvl, e, "level");
    chk(tk_vec, 16'hFFFC - 2 * e, "vector");
    bus(`ADDR_CTRL, 1'h1, 32'h40E3);
    bus(`ADDR_FLAGS, 1'h1, 32'h007F_FFFF);
    bus(sa(e), 1'h0, 32'h0);
    chk(rd, 32'h0, "cleared");
  endtask
  always @(posedge hclk)
    if (irq_take === 1'h1) begin
      tk_n <= tk_n + 1;
      tk_lvl <= irq_level;
      tk_vec <= irq_vector;
    end
  initial begin
    hclk = 1'h0;
    forever #10 hclk = ~hclk;
  end
  initial begin
    #(20 * 40000);
    fails = fails + 1;
    give_verdict;
  end
  initial begin
    {hresetn, hsel, hwrite, trap, brk, haddr, htrans, hwdata, p, mx, gap} = 0;
    fails = 0;
    num_checks = 0;
    tk_n = 0;
    rd = $urandom(38);
    repeat (2) @(posedge hclk);
    hresetn <= 1'h1;
    bus(`ADDR_STAT1, 1'h0, 32'h0);
    chk(rd, 32'h0, "reset status");
    chk({hreadyout, hresp}, 32'h2, "bus response");
    bus(8'h40, 1'h0, 32'h0);
    chk(rd, 32'h0, "unmapped");
    bus(`ADDR_ENABLE, 1'h1, 32'h007F_FFFF);
    bus(`ADDR_CTRL, 1'h1, 32'hE3);
    for (l = 1; l < 17; l = l + 1) begin
      gap <= l[0] ? 4'h0 : 4'h7;
      run(16'h1 << (l - 1), l);
    end
    repeat (4) begin
      a = 1 + $urandom % 16;
      b = 1 + $urandom % 16;
      run((16'h1 << (a - 1)) | (16'h1 << (b - 1)), a < b ? a : b);
    end
    for (l = 0; l < 2; l = l + 1) begin
      n0 = tk_n;
      @(posedge hclk);
      trap <= l == 0;
      brk <= l == 1;
      @(posedge hclk);
      trap <= 1'h0;
      brk <= 1'h0;
      wait_take;
      chk(tk_n, n0 + 1, "trap taken");
      chk(tk_lvl, 32'h0, "trap level");
      chk(tk_vec, 32'hFFFC, "trap vector");
    end
    give_verdict;
  end
endmodule
bind irq_source_ctrl irq_src_asserts u_chk (.hclk(hclk), .hresetn(hresetn),
  .soft_trap_instr(soft_trap_instr), .break_hit(break_hit), .instr_done(instr_done),
  .pc_in(pc_in), .irq_take(irq_take), .irq_vector(irq_vector), .stack_pc(stack_pc),
  .irq_level(irq_level), .ibit(ibit));
